// file: lff_pkg.sv
`default_nettype none
package lff_pkg;
  // ----------------------------------------------------------------------
  // Device register map and reset values
  // ----------------------------------------------------------------------
  localparam int          NCH           = 16;
  localparam logic [7:0]  REG_MODE_CTL  = 8'h01;
  localparam logic [7:0]  REG_FLAGS_UP  = 8'h1D;
  localparam logic [7:0]  REG_FLAGS_LO  = 8'h1E;
  localparam logic [7:0]  FLAGS_RST     = 8'hFF;
  localparam logic [7:0]  MODE_CTL_RST  = 8'h00;
  localparam int          MODE_CLR_BIT  = 7;
  localparam logic [6:0]  DEV_ADDR_DFLT = 7'h60;
  // ----------------------------------------------------------------------
  // Soft reset call
  // ----------------------------------------------------------------------
  localparam logic [7:0]  SOFT_RST_ADDR = 8'hD6;
  localparam logic [7:0]  SOFT_RST_KEY1 = 8'hA5;
  localparam logic [7:0]  SOFT_RST_KEY2 = 8'h5A;
  // ----------------------------------------------------------------------
  // Host timing: quarter of a 1 us serial clock period, rounded up
  // ----------------------------------------------------------------------
  localparam int          CLK_MHZ       = 125;
  localparam int          T_QTR_NS      = 250;
  localparam int          QTR_CYC       = (T_QTR_NS * CLK_MHZ + 999) / 1000;
  // ----------------------------------------------------------------------
  // Host register map and command fields
  // ----------------------------------------------------------------------
  localparam logic [3:0]  HREG_CMD      = 4'h0;
  localparam logic [3:0]  HREG_STAT     = 4'h4;
  localparam int          CMD_START     = 8;
  localparam int          CMD_STOP      = 9;
  localparam int          CMD_READ      = 10;
  localparam int          CMD_NACK      = 11;
endpackage
`default_nettype wire

// file: lff_if.sv
`default_nettype none
interface lff_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  wire  scl;
  wire  sda;

  // Open-drain wired-AND with pull-ups
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));

  modport host (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe,
                input scl, input sda);
  modport dev  (output d_sda_o, output d_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

// file: lff_dev.sv
// Notes on behaviour
// - Two read-only flag registers, reset all ones.
// - Host initialises flags: clear bit 1, then 0.
// - Enabled channel reads 1 when current adequate.
// - Off channel reads 0, no detection.
// - Global overheat shuts all, flags all channels.
// - Channel overheat shuts and flags that channel.
// - Channel overheat detection only while on.
// - Channel restarts when cool if latch on.
// - Overheat fault stays latched until host clears.
// - Open and overheat faults combine per flag.
// - Clear bit 1 clears; 0 re-enables flagging.
// - Power-on reset defaults everything, channels off.
// - External reset low holds defaults.
// - Reset address acked only with write direction.
// - First key byte acked only if correct.
// - Second key byte acked only if correct.
// - Bytes after the keys are not acked.
// - Keys acked plus stop resets the device.
// - Master sends start, address, keys, stop.
// - Malformed call never resets registers.
// - Start and stop decoded while clock high.
`default_nettype none
module lff_dev #(
  parameter logic [6:0] DEV_ADDR = lff_pkg::DEV_ADDR_DFLT
) (
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  input  wire logic                    rst_ext_n,
  input  wire logic [lff_pkg::NCH-1:0] ch_on,
  input  wire logic [lff_pkg::NCH-1:0] ch_cur_ok,
  input  wire logic [lff_pkg::NCH-1:0] ch_hot,
  input  wire logic                    glob_hot,
  lff_if.dev                           bus,
  output logic      [lff_pkg::NCH-1:0] ch_drive
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_RX   = 3'b010,
    S_ACK  = 3'b011,
    S_TX   = 3'b100,
    S_MACK = 3'b101,
    S_TXLD = 3'b110
  } lff_dstate_t;

  lff_dstate_t             state_r;
  logic                    scl_q_r;
  logic                    sda_q_r;
  logic [7:0]              sh_r;
  logic [7:0]              tx_r;
  logic [2:0]              cnt_r;
  logic [1:0]              idx_r;
  logic                    sw_r;
  logic                    arm_r;
  logic                    rw_r;
  logic                    soft_rst_r;
  logic [7:0]              ptr_r;
  logic [7:0]              mode_ctl_r;
  logic                    sda_oe_r;
  logic                    clr_seen_r;
  logic                    init_r;
  logic [lff_pkg::NCH-1:0] ot_r;
  logic [lff_pkg::NCH-1:0] flags_r;
  logic [lff_pkg::NCH-1:0] drive_r;
  logic [lff_pkg::NCH-1:0] flag_w;

  // --------------------------------------------------------------------
  // Bus condition decode
  // --------------------------------------------------------------------
  // Inputs are synchronous, so one stage of history is enough for edges
  wire        srst_w  = ~rst_ext_n | soft_rst_r;
  wire        start_w = bus.scl & scl_q_r & sda_q_r & ~bus.sda;
  wire        stop_w  = bus.scl & scl_q_r & ~sda_q_r & bus.sda;
  wire        rise_w  = bus.scl & ~scl_q_r;
  wire        fall_w  = ~bus.scl & scl_q_r;
  wire [7:0]  byte_w  = {sh_r[6:0], bus.sda};
  wire        last_w  = (cnt_r == 3'h7);

  // Acknowledge decision for the byte completing on this rising edge
  // A read on the reset address differs in bit 0, so it never matches
  wire        is_sw_w  = (state_r == S_ADDR) && (byte_w == lff_pkg::SOFT_RST_ADDR);
  wire        is_own_w = (state_r == S_ADDR) && (byte_w[7:1] == DEV_ADDR);
  wire        key1_w   = sw_r && (idx_r == 2'h0) && (byte_w == lff_pkg::SOFT_RST_KEY1);
  wire        key2_w   = sw_r && (idx_r == 2'h1) && (byte_w == lff_pkg::SOFT_RST_KEY2);
  wire        wr_w     = (state_r == S_RX) && !sw_r;
  wire        ack_w    = is_sw_w | is_own_w | key1_w | key2_w | wr_w;

  // Readback multiplexer; unmapped pointers read zero
  wire [7:0]  rd_w = (ptr_r == lff_pkg::REG_FLAGS_UP) ? flags_r[15:8] :
                     (ptr_r == lff_pkg::REG_FLAGS_LO) ? flags_r[7:0] :
                     (ptr_r == lff_pkg::REG_MODE_CTL) ? mode_ctl_r : 8'h00;

  // --------------------------------------------------------------------
  // Serial slave state machine
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      state_r  <= S_IDLE;
      sh_r     <= 8'h00;
      tx_r     <= 8'h00;
      cnt_r    <= 3'h0;
      idx_r    <= 2'h0;
      sw_r     <= 1'b0;
      arm_r    <= 1'b0;
      rw_r     <= 1'b0;
      soft_rst_r <= 1'b0;
      ptr_r    <= 8'h00;
      mode_ctl_r <= lff_pkg::MODE_CTL_RST;
      sda_oe_r <= 1'b0;
    end
    else if (srst_w)
    begin
      state_r  <= S_IDLE;
      cnt_r    <= 3'h0;
      idx_r    <= 2'h0;
      sw_r     <= 1'b0;
      arm_r    <= 1'b0;
      rw_r     <= 1'b0;
      soft_rst_r <= 1'b0;
      ptr_r    <= 8'h00;
      mode_ctl_r <= lff_pkg::MODE_CTL_RST;
      sda_oe_r <= 1'b0;
    end
    else
    begin
      soft_rst_r <= 1'b0;
      if (start_w)
      begin
        state_r  <= S_ADDR;
        cnt_r    <= 3'h0;
        idx_r    <= 2'h0;
        sw_r     <= 1'b0;
        arm_r    <= 1'b0;
        sda_oe_r <= 1'b0;
      end
      else if (stop_w)
      begin
        state_r  <= S_IDLE;
        sda_oe_r <= 1'b0;
        soft_rst_r <= arm_r;
        arm_r    <= 1'b0;
      end
      else
        case (state_r)
          S_ADDR, S_RX:
            if (rise_w)
            begin
              sh_r  <= byte_w;
              cnt_r <= cnt_r + 3'h1;
              if (last_w)
              begin
                state_r <= ack_w ? S_ACK : S_IDLE;
                if (is_sw_w)
                  sw_r <= 1'b1;
                if (is_own_w)
                  rw_r <= byte_w[0];
                if (state_r == S_RX && idx_r != 2'h3)
                  idx_r <= idx_r + 2'h1;
                if (wr_w && idx_r == 2'h0)
                  ptr_r <= byte_w;
                if (wr_w && idx_r != 2'h0 && ptr_r == lff_pkg::REG_MODE_CTL)
                  mode_ctl_r <= byte_w;
                if (key2_w)
                  arm_r <= 1'b1;
                else if (!ack_w)
                  arm_r <= 1'b0;
              end
            end
          S_ACK:
            if (fall_w)
            begin
              // First falling edge opens the ack slot, the second closes it
              if (!sda_oe_r)
                sda_oe_r <= 1'b1;
              else if (rw_r && !sw_r)
              begin
                tx_r     <= rd_w;
                sda_oe_r <= ~rd_w[7];
                cnt_r    <= 3'h0;
                state_r  <= S_TX;
              end
              else
              begin
                sda_oe_r <= 1'b0;
                state_r  <= S_RX;
              end
            end
          S_TX:
            if (fall_w)
            begin
              cnt_r <= cnt_r + 3'h1;
              if (last_w)
              begin
                sda_oe_r <= 1'b0;
                state_r  <= S_MACK;
              end
              else
              begin
                tx_r     <= {tx_r[6:0], 1'b0};
                sda_oe_r <= ~tx_r[6];
              end
            end
          S_MACK:
            if (rise_w)
              state_r <= bus.sda ? S_IDLE : S_TXLD;
          S_TXLD:
            if (fall_w)
            begin
              tx_r     <= rd_w;
              sda_oe_r <= ~rd_w[7];
              state_r  <= S_TX;
            end
          default:
            state_r <= S_IDLE;
        endcase
    end

  // Line history; not reset by the soft reset so edges stay coherent
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end
    else
    begin
      scl_q_r <= bus.scl;
      sda_q_r <= bus.sda;
    end

  // --------------------------------------------------------------------
  // Flag initialisation: flags read all ones until the clear pulse ends
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      clr_seen_r <= 1'b0;
      init_r     <= 1'b0;
    end
    else if (srst_w)
    begin
      clr_seen_r <= 1'b0;
      init_r     <= 1'b0;
    end
    else
    begin
      if (mode_ctl_r[lff_pkg::MODE_CLR_BIT])
        clr_seen_r <= 1'b1;
      if (clr_seen_r && !mode_ctl_r[lff_pkg::MODE_CLR_BIT])
        init_r <= 1'b1;
    end

  // --------------------------------------------------------------------
  // Per-channel fault latches and output gating
  // --------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < lff_pkg::NCH; gi++)
    begin : g_ch
      // Open load only seen while on; overheat latch overrides
      assign flag_w[gi] = ch_on[gi] & ch_cur_ok[gi] & ~ot_r[gi];

      // Clear bit held high keeps latches empty: clear wins here
      always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
          ot_r[gi] <= 1'b0;
        else if (srst_w || mode_ctl_r[lff_pkg::MODE_CLR_BIT])
          ot_r[gi] <= 1'b0;
        else if (glob_hot || (ch_on[gi] && ch_hot[gi]))
          ot_r[gi] <= 1'b1;

      // Shutdown lasts only while hot; restarts if latch still on
      always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
          drive_r[gi] <= 1'b0;
        else if (srst_w)
          drive_r[gi] <= 1'b0;
        else
          drive_r[gi] <= ch_on[gi] & ~glob_hot & ~ch_hot[gi];

      always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
          flags_r[gi] <= 1'b1;
        else if (srst_w || !init_r)
          flags_r[gi] <= 1'b1;
        else
          flags_r[gi] <= flag_w[gi];
    end
  endgenerate

  // Open-drain: output value is always low, enable selects pulling
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      bus.d_sda_o <= 1'b0;
    else
      bus.d_sda_o <= 1'b0;

  assign bus.d_sda_oe = sda_oe_r;
  assign ch_drive     = drive_r;
endmodule // lff_dev
`default_nettype wire

// file: lff_host.sv
`default_nettype none
module lff_host #(
  parameter int QTR = lff_pkg::QTR_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  lff_if.host              bus
);
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_START = 2'b01,
    H_BIT   = 2'b10,
    H_STOP  = 2'b11
  } lff_hstate_t;

  lff_hstate_t st_r;
  logic [11:0] cmd_r;
  logic [7:0]  sh_r;
  logic [7:0]  rx_r;
  logic [1:0]  ph_r;
  logic [3:0]  bit_r;
  logic [15:0] qc_r;
  logic        busy_r;
  logic        nack_r;
  logic        scl_oe_r;
  logic        sda_oe_r;
  logic [31:0] dat_r;
  logic        ack_r;

  // ----------------------------------------------------------------------
  // Bus slave decode
  // ----------------------------------------------------------------------
  wire        req_w  = wb_cyc_i & wb_stb_i & ~ack_r;
  // Command lands at the edge where the master sees ack high, not earlier
  wire        cmd_w  = wb_cyc_i & wb_stb_i & ack_r & wb_we_i & (wb_adr_i == lff_pkg::HREG_CMD) &
                       (wb_sel_i[1:0] == 2'h3) & ~busy_r;
  wire [31:0] stat_w = {16'h0000, rx_r, 6'h00, nack_r, busy_r};
  wire        tick_w = busy_r && (qc_r == 16'(QTR - 1));
  wire        data_w = (bit_r < 4'h8);
  wire        rd_w   = cmd_r[lff_pkg::CMD_READ];

  // Single-cycle answer; command writes while busy are dropped
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= req_w;
      dat_r <= (req_w && !wb_we_i && wb_adr_i == lff_pkg::HREG_STAT) ? stat_w : 32'h0000_0000;
    end

  // Quarter-period timebase, restarted by each new command
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      qc_r <= 16'h0000;
    else if (!busy_r || tick_w)
      qc_r <= 16'h0000;
    else
      qc_r <= qc_r + 16'h0001;

  // ----------------------------------------------------------------------
  // Line sequencer: four quarters per start, bit and stop
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      st_r     <= H_IDLE;
      cmd_r    <= 12'h000;
      sh_r     <= 8'h00;
      rx_r     <= 8'h00;
      ph_r     <= 2'h0;
      bit_r    <= 4'h0;
      busy_r   <= 1'b0;
      nack_r   <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else if (cmd_w)
    begin
      // Software orders start, address, keys, stop for a reset call
      cmd_r  <= wb_dat_i[11:0];
      sh_r   <= wb_dat_i[7:0];
      busy_r <= 1'b1;
      ph_r   <= 2'h0;
      bit_r  <= 4'h0;
      st_r   <= wb_dat_i[lff_pkg::CMD_START] ? H_START : H_BIT;
    end
    else if (tick_w)
    begin
      ph_r <= ph_r + 2'h1;
      case (st_r)
        H_START:
          case (ph_r)
            2'h0:    sda_oe_r <= 1'b0;
            2'h1:    scl_oe_r <= 1'b0;
            2'h2:    sda_oe_r <= 1'b1;
            default:
            begin
              scl_oe_r <= 1'b1;
              st_r     <= H_BIT;
            end
          endcase
        H_BIT:
          case (ph_r)
            2'h0:    sda_oe_r <= data_w ? (~rd_w & ~sh_r[7]) :
                                          (rd_w & ~cmd_r[lff_pkg::CMD_NACK]);
            2'h1:    scl_oe_r <= 1'b0;
            2'h2:
              if (data_w)
                sh_r <= {sh_r[6:0], bus.sda};
              else if (!rd_w)
                nack_r <= bus.sda;
            default:
            begin
              scl_oe_r <= 1'b1;
              bit_r    <= bit_r + 4'h1;
              if (!data_w)
              begin
                if (rd_w)
                  rx_r <= sh_r;
                sda_oe_r <= 1'b0;
                st_r     <= cmd_r[lff_pkg::CMD_STOP] ? H_STOP : H_IDLE;
                busy_r   <= cmd_r[lff_pkg::CMD_STOP];
              end
            end
          endcase
        H_STOP:
          case (ph_r)
            2'h0:    sda_oe_r <= 1'b1;
            2'h1:    scl_oe_r <= 1'b0;
            2'h2:    sda_oe_r <= 1'b0;
            default:
            begin
              busy_r <= 1'b0;
              st_r   <= H_IDLE;
            end
          endcase
        default:
          busy_r <= 1'b0;
      endcase
    end

  // Open-drain value bits stay low; enables do the signalling
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      bus.m_scl_o <= 1'b0;
      bus.m_sda_o <= 1'b0;
    end
    else
    begin
      bus.m_scl_o <= 1'b0;
      bus.m_sda_o <= 1'b0;
    end

  assign bus.m_scl_oe = scl_oe_r;
  assign bus.m_sda_oe = sda_oe_r;
  assign wb_ack_o     = ack_r;
  assign wb_dat_o     = dat_r;
endmodule // lff_host
`default_nettype wire

// file: lff_monitor.sv
`default_nettype none
// ------------------------------------------------------------
// Channel gating and serial line checks of the device end
// ------------------------------------------------------------
module lff_monitor (
  input wire logic                    clk,
  input wire logic                    reset_n,
  input wire logic                    rst_ext_n,
  input wire logic [lff_pkg::NCH-1:0] ch_on,
  input wire logic [lff_pkg::NCH-1:0] ch_hot,
  input wire logic                    glob_hot,
  input wire logic [lff_pkg::NCH-1:0] ch_drive,
  input wire logic                    scl,
  input wire logic                    sda,
  input wire logic                    d_sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, quiet during power-on reset
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Output stage follows latch and sensors one cycle late
  AST_GLOB_SHUT: assert property ($past(glob_hot) |-> ch_drive == '0)
    else $error("outputs driven after global overheat");
  AST_CH_SHUT: assert property ((ch_drive & $past(ch_hot)) == '0)
    else $error("hot channel still driven");
  AST_LATCH_OFF: assert property ((ch_drive & ~$past(ch_on)) == '0)
    else $error("channel driven with latch off");
  // A long idle bus rules out a soft reset in flight, so drive must track
  AST_RESTART: assert property ((rst_ext_n && scl && sda) [*8] |->
    ch_drive == ($past(glob_hot) ? '0 : $past(ch_on) & ~$past(ch_hot)))
    else $error("channel did not restart after cooling");
  AST_EXT_RST: assert property (!rst_ext_n |=> ch_drive == '0 && !d_sda_oe)
    else $error("device active while reset pin low");
  // SDA may move only with SCL low, otherwise the device forges start or stop
  AST_SDA_LOWPH: assert property ($changed(d_sda_oe) |-> !scl)
    else $error("device moved data line with clock high");
  AST_START_QUIET: assert property (scl && $fell(sda) |=> !d_sda_oe [*8])
    else $error("device pulled data line after start");
  AST_STOP_QUIET: assert property (scl && $rose(sda) |=> !d_sda_oe [*8])
    else $error("device pulled data line after stop");
endmodule // lff_monitor
`default_nettype wire

// file: lff_tb.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Stimulus, reference model and the two ends
  // ------------------------------------------------------------
  localparam logic [7:0] DEV_W = {lff_pkg::DEV_ADDR_DFLT, 1'b0};
  logic        clk       = 1'b0;
  logic        reset_n   = 1'b0;
  logic        rst_ext_n = 1'b1;
  logic        glob_hot  = 1'b0;
  logic        wb_cyc    = 1'b0;
  logic        wb_stb    = 1'b0;
  logic        wb_we     = 1'b0;
  logic [3:0]  wb_adr    = 4'h0;
  logic [31:0] wb_wdat   = 32'h0;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic [15:0] ch_on     = 16'h0;
  logic [15:0] ch_ok     = 16'h0;
  logic [15:0] ch_hot    = 16'h0;
  logic [15:0] ch_drive;
  logic [31:0] st;
  int          err_count   = 0;
  int          checks_done = 0;
  // Model: overheat latches, flags initialised, clear bit held
  logic [15:0] m_lat  = 16'h0;
  bit          m_init = 1'b0;
  bit          m_clr  = 1'b0;
  // Soft reset calls: bytes (bit 8 = start), byte count, expected nacks
  logic [11:0] call_b [6][4] = '{'{12'h1D6, 12'h0A5, 12'h05A, 12'h000},
    '{12'h1D7, 12'h000, 12'h000, 12'h000}, '{12'h1D6, 12'h03C, 12'h000, 12'h000},
    '{12'h1D6, 12'h0A5, 12'h0C3, 12'h000}, '{12'h1D6, 12'h0A5, 12'h05A, 12'h077},
    '{12'h1D6, 12'h0A5, 12'h05A, 12'h1C0}};
  int          call_n [6]  = '{3, 1, 2, 3, 4, 4};
  logic [3:0]  call_nk [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h0};

  // Free running system clock
  always #4 clk = ~clk;

  lff_if bus_if ();
  lff_host #(.QTR(4)) i_lff_host (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .bus(bus_if.host));
  lff_dev i_lff_dev (.clk(clk), .reset_n(reset_n), .rst_ext_n(rst_ext_n), .ch_on(ch_on),
    .ch_cur_ok(ch_ok), .ch_hot(ch_hot), .glob_hot(glob_hot), .bus(bus_if.dev),
    .ch_drive(ch_drive));
  lff_monitor i_lff_monitor (.clk(clk), .reset_n(reset_n), .rst_ext_n(rst_ext_n),
    .ch_on(ch_on), .ch_hot(ch_hot), .glob_hot(glob_hot), .ch_drive(ch_drive),
    .scl(bus_if.scl), .sda(bus_if.sda), .d_sda_oe(bus_if.d_sda_oe));

  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Classic single cycle; request held until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                         output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_wdat <= wd;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 50);
    rd = wb_rdat;
    check({31'h0, wb_ack}, 32'h1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  // One serial byte; busy is polled, a bounded count guards a stuck host
  task automatic host_cmd(input logic [11:0] c, output logic [31:0] s);
    logic [31:0] d;
    int n;
    n = 0;
    wb_xfer(1'b1, lff_pkg::HREG_CMD, {20'h0, c}, d);
    do
    begin
      wb_xfer(1'b0, lff_pkg::HREG_STAT, 32'h0, s);
      n++;
    end
    while (s[0] !== 1'b0 && n < 400);
    check({31'h0, s[0]}, 32'h0);
  endtask

  task automatic dev_wr(input logic [7:0] r, input logic [7:0] v);
    host_cmd({4'h1, DEV_W}, st);
    host_cmd({4'h0, r}, st);
    host_cmd({4'h2, v}, st);
    check(st & 32'h2, 32'h0);
  endtask

  task automatic dev_rd(input logic [7:0] r, output logic [7:0] v);
    host_cmd({4'h1, DEV_W}, st);
    host_cmd({4'h0, r}, st);
    host_cmd({4'h1, DEV_W | 8'h01}, st);
    host_cmd(12'hE00, st);
    v = st[15:8];
  endtask

  // Clear bit: latches held clear while set, flags live after 1 then 0
  task automatic set_clr(input bit b);
    dev_wr(lff_pkg::REG_MODE_CTL, b ? 8'h80 : 8'h00);
    if (b)
      m_lat = 16'h0;
    if (!b && m_clr)
      m_init = 1'b1;
    m_clr = b;
  endtask

  task automatic cmp_flags();
    logic [7:0]  v;
    logic [15:0] e;
    e = m_init ? (ch_on & ch_ok & ~m_lat) : 16'hFFFF;
    dev_rd(lff_pkg::REG_FLAGS_UP, v);
    check({24'h0, v}, {24'h0, e[15:8]});
    dev_rd(lff_pkg::REG_FLAGS_LO, v);
    check({24'h0, v}, {24'h0, e[7:0]});
  endtask

  // Overheat pulse, then cool down; outputs must come back on their own
  task automatic heat(input logic g, input logic [15:0] h);
    @(posedge clk);
    glob_hot <= g;
    ch_hot   <= h;
    repeat (3) @(posedge clk);
    check({16'h0, ch_drive}, {16'h0, g ? 16'h0 : ch_on & ~h});
    glob_hot <= 1'b0;
    ch_hot   <= 16'h0;
    repeat (3) @(posedge clk);
    check({16'h0, ch_drive}, {16'h0, ch_on});
    if (!m_clr)
      m_lat = m_lat | (g ? 16'hFFFF : h & ch_on);
  endtask

  // ------------------------------------------------------------
  // Test sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h4B1DD6FA));
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    host_cmd({4'h1, DEV_W}, st);
    host_cmd({4'h0, lff_pkg::REG_FLAGS_UP}, st);
    host_cmd(12'h200, st);
    cmp_flags();
    wb_xfer(1'b1, 4'h8, 32'hFFFFFFFF, st);
    wb_xfer(1'b0, 4'h8, 32'h0, st);
    check(st, 32'h0);
    set_clr(1'b1);
    set_clr(1'b0);
    for (int r = 0; r < 3; r++)
    begin
      @(posedge clk);
      ch_on <= 16'($urandom()) | 16'h0001;
      ch_ok <= 16'($urandom()) & 16'hFFFE;
      heat(1'b0, 16'($urandom()));
      cmp_flags();
    end
    heat(1'b1, 16'h0);
    cmp_flags();
    set_clr(1'b1);
    cmp_flags();
    heat(1'b1, 16'hFFFF);
    set_clr(1'b0);
    cmp_flags();
    for (int k = 0; k < 6; k++)
    begin
      set_clr(1'b1);
      set_clr(1'b0);
      for (int j = 0; j < call_n[k]; j++)
      begin
        host_cmd(call_b[k][j] | (j == call_n[k] - 1 ? 12'h200 : 12'h000), st);
        check(st & 32'h2, {30'h0, call_nk[k][j], 1'b0});
      end
      if (k == 0)
        m_init = 1'b0;
      cmp_flags();
    end
    // Pin reset first, then a second power-on reset in mid-run
    for (int p = 0; p < 2; p++)
    begin
      set_clr(1'b1);
      set_clr(1'b0);
      @(posedge clk);
      rst_ext_n <= (p != 0);
      reset_n   <= (p == 0);
      repeat (4) @(posedge clk);
      check({16'h0, ch_drive}, 32'h0);
      rst_ext_n <= 1'b1;
      reset_n   <= 1'b1;
      m_init = 1'b0;
      m_clr  = 1'b0;
      cmp_flags();
    end
    tally_and_finish();
  end

  // Whole run needs well under this span; a hang counts as a mismatch
  initial
  begin
    #800_000;
    err_count++;
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
